// ==== logic/cad_pkg.sv ====
// Constants and types for the compatibility address decoder
`default_nettype none
package cad_pkg;
	// ----------------------------------------
	// Address widths
	// ----------------------------------------
	localparam int ADDR_W = 40;
	localparam int CPU_ADDR_W = 36;
	localparam int MEM_ADDR_W = 36;
	localparam int IO_ADDR_W = 16;
	localparam int COMPAT_AW = 20;
	localparam int LOW_AW = 32;
	localparam logic [ADDR_W-1:0] CPU_ADDR_MASK = 40'h0F_FFFF_FFFF;
	// ----------------------------------------
	// Compatibility area boundaries
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] VGA_BASE = 40'h00_000A_0000;
	localparam logic [ADDR_W-1:0] SHADOW_BASE = 40'h00_000C_0000;
	localparam logic [ADDR_W-1:0] COMPAT_TOP = 40'h00_0010_0000;
	// ----------------------------------------
	// Fixed system regions
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] SYS_BASE = 40'h00_FE00_0000;
	localparam logic [ADDR_W-1:0] INTR_BASE = 40'h00_FEE0_0000;
	localparam logic [ADDR_W-1:0] INTR_TOP = 40'h00_FEF0_0000;
	localparam logic [ADDR_W-1:0] FOUR_GB = 40'h01_0000_0000;
	// ----------------------------------------
	// Attribute-programmable segments
	// ----------------------------------------
	localparam int SEG_N = 13;
	localparam int SEG_SMALL_N = 12;
	localparam int SEG_SHIFT = 14;
	localparam int SEG_F_SHIFT = 16;
	localparam logic [5:0] SEG_C_IDX = 6'h30;
	localparam logic [3:0] SEG_F_IDX = 4'hF;
	localparam int ATTR_W = 2;
	localparam int ATTR_RD_BIT = 0;
	localparam int ATTR_WR_BIT = 1;
	localparam logic [SEG_N*ATTR_W-1:0] ATTR_RESET = 26'h000_0000;
	// ----------------------------------------
	// Destinations
	// ----------------------------------------
	typedef enum logic [2:0] {
		DEST_NONE = 3'h0,
		DEST_MEM = 3'h1,
		DEST_LINK = 3'h2,
		DEST_GFX = 3'h3,
		DEST_INTR = 3'h4,
		DEST_SYS = 3'h5
	} cad_dest_t;
endpackage
`default_nettype wire

// ==== logic/cad_seg_lookup.sv ====
// Segment attribute lookup for the shadow segments below 1 MB
`timescale 1ns/10ps
`default_nettype none
module cad_seg_lookup
	import cad_pkg::*;
(
	// Request
	input wire logic [COMPAT_AW-1:0] i_addr,
	input wire logic i_write,
	// Settings
	input wire logic [SEG_N*ATTR_W-1:0] i_attr,
	// Result
	output logic o_hit,
	output logic o_to_mem
);
	logic [SEG_N-1:0] hit;
	logic [SEG_N-1:0] to_mem;

	// ----------------------------------------
	// Per-segment match and attribute
	// ----------------------------------------
	for (genvar g = 0; g < SEG_N; g++) begin : g_seg
		if (g < SEG_SMALL_N) begin : g_small
			assign hit[g] = (i_addr[COMPAT_AW-1:SEG_SHIFT] == 6'(SEG_C_IDX + g));
		end else begin : g_big
			assign hit[g] = (i_addr[COMPAT_AW-1:SEG_F_SHIFT] == SEG_F_IDX);
		end
		assign to_mem[g] = hit[g] & (i_write ? i_attr[g*ATTR_W+ATTR_WR_BIT]
			: i_attr[g*ATTR_W+ATTR_RD_BIT]);
	end

	assign o_hit = |hit;
	assign o_to_mem = |to_mem;
endmodule // cad_seg_lookup
`default_nettype wire

// ==== logic/cad_decoder.sv ====
// System address decoder for processor and I/O requests
//
// Contract
// - Decode 36-bit processor addresses, carry 40 bits
// - I/O space is 16 bits wide
// - Decode interrupt region and top 32MB region
// - Memory gets a 36-bit local address
// - Outbound addresses under 4GB use 32-bit format
// - 64-bit format only above 32 bits
// - Compatibility area routes to memory, link, graphics
// - Low 1MB of DRAM never relocated or aliased
// - Memory-mapped low area reachable by all sources
// - Lowest 640KB always goes to memory
// - Video range to link or graphics port; processor SMM accesses go to memory when enabled
// - 768-896KB as eight 16KB segments
// - 896-960KB as four 16KB segments
// - 960KB-1MB is one segment
// - Thirteen segments with read and write enables
// - Two-bit setting picks read and write targets
// - After reset, programmable areas go to link
`timescale 1ns/10ps
`default_nettype none
module cad_decoder
	import cad_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Request
	input wire logic i_req_valid,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic i_req_write,
	input wire logic i_req_io,
	input wire logic i_req_from_cpu,
	input wire logic i_req_smm,
	// Configuration
	input wire logic i_cfg_wr,
	input wire logic [SEG_N*ATTR_W-1:0] i_segment_attribute_setting,
	input wire logic i_vga_to_gfx,
	input wire logic i_system_management_space_en,
	input wire logic [ADDR_W-1:0] i_low_mem_top,
	input wire logic [ADDR_W-1:0] i_high_mem_top,
	// Configuration status
	output logic [SEG_N*ATTR_W-1:0] o_segment_attribute_setting,
	output logic o_vga_to_gfx,
	output logic o_system_management_space_en,
	// Routing result
	output logic o_rsp_valid,
	output cad_dest_t o_dest,
	output logic [MEM_ADDR_W-1:0] o_mem_addr,
	output logic [ADDR_W-1:0] o_out_addr,
	output logic o_out_fmt64,
	output logic [IO_ADDR_W-1:0] o_io_addr
);
	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic [SEG_N*ATTR_W-1:0] attr_q;
	logic [SEG_N*ATTR_W-1:0] attr_d;
	logic vga_gfx_q;
	logic vga_gfx_d;
	logic smm_en_q;
	logic smm_en_d;

	always_comb begin
		attr_d = attr_q;
		vga_gfx_d = vga_gfx_q;
		smm_en_d = smm_en_q;
		if (i_cfg_wr) begin
			attr_d = i_segment_attribute_setting;
			vga_gfx_d = i_vga_to_gfx;
			smm_en_d = i_system_management_space_en;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			attr_q <= ATTR_RESET;
			vga_gfx_q <= 1'b0;
			smm_en_q <= 1'b0;
		end else begin
			attr_q <= attr_d;
			vga_gfx_q <= vga_gfx_d;
			smm_en_q <= smm_en_d;
		end
	end

	assign o_segment_attribute_setting = attr_q;
	assign o_vga_to_gfx = vga_gfx_q;
	assign o_system_management_space_en = smm_en_q;

	// ----------------------------------------
	// Address qualification
	// ----------------------------------------
	logic [ADDR_W-1:0] addr_eff;
	logic seg_hit;
	logic seg_to_mem;
	logic smm_hit;

	assign addr_eff = i_req_from_cpu ? (i_req_addr & CPU_ADDR_MASK) : i_req_addr;
	assign smm_hit = smm_en_q & i_req_from_cpu & i_req_smm;

	cad_seg_lookup u_seg (
		.i_addr(addr_eff[COMPAT_AW-1:0]),
		.i_write(i_req_write),
		.i_attr(attr_q),
		.o_hit(seg_hit),
		.o_to_mem(seg_to_mem)
	);

	// ----------------------------------------
	// Destination decode
	// ----------------------------------------
	logic valid_d;
	logic valid_q;
	cad_dest_t dest_d;
	cad_dest_t dest_q;
	logic [MEM_ADDR_W-1:0] mem_addr_d;
	logic [MEM_ADDR_W-1:0] mem_addr_q;
	logic [ADDR_W-1:0] out_addr_d;
	logic [ADDR_W-1:0] out_addr_q;
	logic fmt64_d;
	logic fmt64_q;
	logic [IO_ADDR_W-1:0] io_addr_d;
	logic [IO_ADDR_W-1:0] io_addr_q;

	always_comb begin
		valid_d = i_req_valid;
		dest_d = DEST_NONE;
		if (i_req_valid) begin
			if (i_req_io) begin
				dest_d = DEST_LINK;
			end else if (addr_eff < VGA_BASE) begin
				dest_d = DEST_MEM;
			end else if (addr_eff < SHADOW_BASE) begin
				if (smm_hit) begin
					dest_d = DEST_MEM;
				end else if (vga_gfx_q) begin
					dest_d = DEST_GFX;
				end else begin
					dest_d = DEST_LINK;
				end
			end else if (addr_eff < COMPAT_TOP) begin
				dest_d = (seg_hit && seg_to_mem) ? DEST_MEM : DEST_LINK;
			end else if (addr_eff >= INTR_BASE && addr_eff < INTR_TOP) begin
				dest_d = DEST_INTR;
			end else if (addr_eff >= SYS_BASE && addr_eff < FOUR_GB) begin
				dest_d = DEST_SYS;
			end else if (addr_eff < FOUR_GB) begin
				dest_d = (addr_eff < i_low_mem_top) ? DEST_MEM : DEST_LINK;
			end else begin
				dest_d = (addr_eff < i_high_mem_top) ? DEST_MEM : DEST_LINK;
			end
		end
		out_addr_d = i_req_io ? {{(ADDR_W-IO_ADDR_W){1'b0}}, i_req_addr[IO_ADDR_W-1:0]}
			: addr_eff;
		io_addr_d = i_req_io ? i_req_addr[IO_ADDR_W-1:0] : '0;
		// Identity mapping keeps the low 1 MB of DRAM in place
		mem_addr_d = (dest_d == DEST_MEM) ? addr_eff[MEM_ADDR_W-1:0] : '0;
		fmt64_d = (dest_d == DEST_LINK || dest_d == DEST_GFX)
			&& (|out_addr_d[ADDR_W-1:LOW_AW]);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			valid_q <= 1'b0;
			dest_q <= DEST_NONE;
			mem_addr_q <= '0;
			out_addr_q <= '0;
			fmt64_q <= 1'b0;
			io_addr_q <= '0;
		end else begin
			valid_q <= valid_d;
			dest_q <= dest_d;
			mem_addr_q <= mem_addr_d;
			out_addr_q <= out_addr_d;
			fmt64_q <= fmt64_d;
			io_addr_q <= io_addr_d;
		end
	end

	assign o_rsp_valid = valid_q;
	assign o_dest = dest_q;
	assign o_mem_addr = mem_addr_q;
	assign o_out_addr = out_addr_q;
	assign o_out_fmt64 = fmt64_q;
	assign o_io_addr = io_addr_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_mem_req;
		i_req_valid && !i_req_io;
	endsequence

	sequence s_shadow_req;
		s_mem_req ##0 (addr_eff >= SHADOW_BASE && addr_eff < COMPAT_TOP);
	endsequence

	sequence s_shadow_link_req;
		s_shadow_req ##0 (attr_q == ATTR_RESET);
	endsequence

	sequence s_video_req;
		s_mem_req ##0 (addr_eff >= VGA_BASE && addr_eff < SHADOW_BASE);
	endsequence

	sequence s_compat_req;
		s_mem_req ##0 (addr_eff < COMPAT_TOP);
	endsequence

	sequence s_seg_f_req;
		s_shadow_req ##0 (addr_eff[COMPAT_AW-1:SEG_F_SHIFT] == SEG_F_IDX);
	endsequence

	AST_ONE_DEST: assert property (o_rsp_valid |-> o_dest != DEST_NONE)
		else $error("Valid response without a destination");

	AST_LATENCY: assert property (i_req_valid |=> o_rsp_valid ##1
		(o_rsp_valid == $past(i_req_valid)))
		else $error("Response not one cycle after request");

	AST_DOS_MEM: assert property (s_mem_req ##0 (addr_eff < VGA_BASE)
		|=> o_dest == DEST_MEM && o_mem_addr == $past(addr_eff[MEM_ADDR_W-1:0]))
		else $error("Low 640KB not routed to memory");

	AST_VIDEO_RANGE: assert property (s_mem_req ##0 (addr_eff >= VGA_BASE
		&& addr_eff < SHADOW_BASE && !smm_hit)
		|=> o_dest == ($past(vga_gfx_q) ? DEST_GFX : DEST_LINK))
		else $error("Video range misrouted");

	AST_RESET_LINK: assert property ($rose(i_rst_n)
		|-> attr_q == ATTR_RESET && !vga_gfx_q)
		else $error("Settings not at link routing after reset");

	AST_SHADOW_DEFAULT: assert property (s_shadow_link_req |=> o_dest == DEST_LINK)
		else $error("Disabled segment not routed to link");

	AST_SHADOW_ATTR: assert property (s_shadow_req ##0 seg_to_mem
		|=> o_dest == DEST_MEM)
		else $error("Enabled segment not routed to memory");

	AST_FMT32: assert property (o_rsp_valid && o_out_addr[ADDR_W-1:LOW_AW] == '0
		|-> !o_out_fmt64)
		else $error("32-bit address sent in 64-bit format");

	AST_FMT64: assert property (o_rsp_valid
		&& (o_dest == DEST_LINK || o_dest == DEST_GFX)
		&& |o_out_addr[ADDR_W-1:LOW_AW] |-> o_out_fmt64)
		else $error("Wide address not sent in 64-bit format");

	AST_CPU36: assert property (i_req_valid && i_req_from_cpu
		|=> o_out_addr[ADDR_W-1:CPU_ADDR_W] == '0)
		else $error("Processor address wider than 36 bits");

	AST_IO16: assert property (i_req_valid && i_req_io |=> o_dest == DEST_LINK
		&& o_io_addr == $past(i_req_addr[IO_ADDR_W-1:0]))
		else $error("I/O request misrouted");

	AST_SYS_REGION: assert property (s_mem_req ##0 (addr_eff >= SYS_BASE
		&& addr_eff < FOUR_GB) |=> o_dest == DEST_SYS || o_dest == DEST_INTR)
		else $error("System region misrouted");

	AST_MEM_ADDR: assert property (o_rsp_valid && o_dest == DEST_MEM
		|-> o_mem_addr == o_out_addr[MEM_ADDR_W-1:0])
		else $error("Memory address relocated");

	AST_IDLE: assert property (!i_req_valid
		|=> !o_rsp_valid && o_dest == DEST_NONE)
		else $error("Response without a request");

	AST_INTR_REGION: assert property (s_mem_req ##0 (addr_eff >= INTR_BASE
		&& addr_eff < INTR_TOP) |=> o_dest == DEST_INTR)
		else $error("Interrupt region misrouted");

	AST_SMM_VIDEO: assert property (s_video_req ##0 smm_hit |=> o_dest == DEST_MEM)
		else $error("System management access not routed to memory");

	AST_IO_FMT: assert property (i_req_valid && i_req_io
		|=> !o_out_fmt64 && o_out_addr[ADDR_W-1:IO_ADDR_W] == '0)
		else $error("I/O address not zero-extended");

	AST_COMPAT_DEST: assert property (s_compat_req
		|=> o_dest == DEST_MEM || o_dest == DEST_LINK || o_dest == DEST_GFX)
		else $error("Compatibility area sent to a fourth destination");

	AST_MEM_ADDR_ZERO: assert property (o_rsp_valid && o_dest != DEST_MEM
		|-> o_mem_addr == '0)
		else $error("Memory address shown for a non-memory request");

	AST_CFG_LOAD: assert property (i_cfg_wr
		|=> o_segment_attribute_setting == $past(i_segment_attribute_setting)
		&& o_vga_to_gfx == $past(i_vga_to_gfx))
		else $error("Settings not loaded");

	AST_CFG_HOLD: assert property (!i_cfg_wr |=> $stable(o_segment_attribute_setting))
		else $error("Settings changed without a load");

	AST_SEG_F_READ: assert property (s_seg_f_req ##0 !i_req_write
		|=> o_dest == ($past(attr_q[(SEG_N-1)*ATTR_W+ATTR_RD_BIT]) ? DEST_MEM : DEST_LINK))
		else $error("Top segment read misrouted");

	AST_SEG_F_WRITE: assert property (s_seg_f_req ##0 i_req_write
		|=> o_dest == ($past(attr_q[(SEG_N-1)*ATTR_W+ATTR_WR_BIT]) ? DEST_MEM : DEST_LINK))
		else $error("Top segment write misrouted");
endmodule // cad_decoder
`default_nettype wire

// ==== bench/cad_requester.sv ====
// Request source model for the processor and I/O side
`timescale 1ns/10ps
`default_nettype none
module cad_requester
	import cad_pkg::*;
(
	// Clock and command
	input wire logic i_mclk,
	input wire logic i_go,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [3:0] i_kind,
	// Request to decoder
	output logic o_req_valid = 1'b0,
	output logic [ADDR_W-1:0] o_req_addr = '0,
	output logic [3:0] o_req_kind = '0
);
	// Released address and kind lines show inverse of last value; valid drops low
	always @(posedge i_mclk) begin
		o_req_valid <= i_go;
		o_req_addr <= i_go ? i_addr : ~o_req_addr;
		o_req_kind <= i_go ? i_kind : ~o_req_kind;
	end
endmodule // cad_requester
`default_nettype wire

// ==== bench/tb_cad_decoder.sv ====
// Self-checking bench for the compatibility address decoder
`timescale 1ns/10ps
`default_nettype none
module tb_cad_decoder;
	import cad_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic go = 1'b0;
	logic [ADDR_W-1:0] c_addr = '0;
	logic [3:0] c_kind = '0;
	logic rv;
	logic [ADDR_W-1:0] ra;
	logic [3:0] rk;
	logic cfg_wr = 1'b0;
	logic [SEG_N*ATTR_W-1:0] attr = '0;
	logic vga = 1'b0;
	logic smm_en = 1'b0;
	logic [ADDR_W-1:0] low_top = 40'h00_8000_0000;
	logic [ADDR_W-1:0] high_top = 40'h10_0000_0000;
	logic [SEG_N*ATTR_W-1:0] rb_attr, sa;
	logic rb_vga, rb_smm, rsp_valid, fmt64;
	cad_dest_t dest;
	logic [MEM_ADDR_W-1:0] mem_addr;
	logic [ADDR_W-1:0] out_addr, sb;
	logic [IO_ADDR_W-1:0] io_addr;
	int failures = 0;
	int n_tests = 0;
	always #4 i_mclk = ~i_mclk;
	cad_requester req_u (.i_mclk(i_mclk), .i_go(go), .i_addr(c_addr), .i_kind(c_kind),
		.o_req_valid(rv), .o_req_addr(ra), .o_req_kind(rk));
	cad_decoder dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req_valid(rv),
		.i_req_addr(ra), .i_req_write(rk[3]), .i_req_io(rk[2]), .i_req_from_cpu(rk[1]),
		.i_req_smm(rk[0]), .i_cfg_wr(cfg_wr), .i_segment_attribute_setting(attr),
		.i_vga_to_gfx(vga), .i_system_management_space_en(smm_en), .i_low_mem_top(low_top),
		.i_high_mem_top(high_top), .o_segment_attribute_setting(rb_attr),
		.o_vga_to_gfx(rb_vga), .o_system_management_space_en(rb_smm),
		.o_rsp_valid(rsp_valid), .o_dest(dest), .o_mem_addr(mem_addr),
		.o_out_addr(out_addr), .o_out_fmt64(fmt64), .o_io_addr(io_addr));
	// ----
	// Access tasks
	// ----
	task automatic chk(input string nm, input logic [ADDR_W-1:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Kind is {write, io, from_cpu, smm}
	task automatic req(input logic [ADDR_W-1:0] a, input logic [3:0] k, input cad_dest_t d,
		input logic f);
		logic [ADDR_W-1:0] ea;
		ea = k[2] ? {24'h00_0000, a[15:0]} : (k[1] ? (a & CPU_ADDR_MASK) : a);
		@(posedge i_mclk);
		go <= 1'b1;
		c_addr <= a;
		c_kind <= k;
		@(posedge i_mclk);
		go <= 1'b0;
		@(posedge i_mclk);
		#1;
		chk("rsp_valid", 40'h00_0000_0001, {39'h0, rsp_valid});
		chk("dest", {37'h0, d}, {37'h0, dest});
		chk("fmt64", {39'h0, f}, {39'h0, fmt64});
		chk("out_addr", ea, out_addr);
		chk("mem_addr", (d == DEST_MEM) ? {4'h0, ea[35:0]} : '0, {4'h0, mem_addr});
		chk("io_addr", k[2] ? {24'h00_0000, a[15:0]} : '0, {24'h00_0000, io_addr});
	endtask
	task automatic cfg(input logic [SEG_N*ATTR_W-1:0] a, input logic v, input logic s);
		@(posedge i_mclk);
		cfg_wr <= 1'b1;
		attr <= a;
		vga <= v;
		smm_en <= s;
		@(posedge i_mclk);
		cfg_wr <= 1'b0;
		#1;
		chk("attr", {14'h0, a}, {14'h0, rb_attr});
		chk("vga_smm", {38'h0, v, s}, {38'h0, rb_vga, rb_smm});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1;
		chk("rb_reset", '0, {12'h0, rb_attr, rb_vga, rb_smm});
		req(40'h00_0000_0000, 4'h8, DEST_MEM, 1'b0);
		req(40'h00_0009_FFFF, 4'h2, DEST_MEM, 1'b0);
		req(40'h00_000A_0000, 4'h2, DEST_LINK, 1'b0);
		req(40'h00_000C_0000, 4'h2, DEST_LINK, 1'b0);
		req(40'h00_000F_0000, 4'hA, DEST_LINK, 1'b0);
		$display("test reset defaults done");
		for (int p = 0; p < 2; p++) begin
			sa = (p == 0) ? 26'h0E4_E4E4 : 26'h31B_1B1B;
			cfg(sa, 1'b0, 1'b0);
			for (int k = 0; k < SEG_N; k++) begin
				sb = 40'h00_000C_3FFF + 40'(k) * 40'h00_0000_4000;
				sb = (k < SEG_SMALL_N) ? sb : 40'h00_000F_FFFF;
				req(sb, 4'h2, sa[2*k] ? DEST_MEM : DEST_LINK, 1'b0);
				req(sb, 4'hA, sa[2*k+1] ? DEST_MEM : DEST_LINK, 1'b0);
			end
		end
		$display("test segment settings done");
		cfg(26'h3FF_FFFF, 1'b1, 1'b1);
		req(40'h00_000B_FFFF, 4'h2, DEST_GFX, 1'b0);
		req(40'h00_000A_0000, 4'h3, DEST_MEM, 1'b0);
		req(40'h00_000A_0000, 4'h1, DEST_GFX, 1'b0);
		req(40'h00_000C_8000, 4'h0, DEST_MEM, 1'b0);
		req(40'h00_FEE0_0000, 4'h2, DEST_INTR, 1'b0);
		req(40'h00_FE00_0000, 4'hA, DEST_SYS, 1'b0);
		req(40'h00_FDFF_FFFF, 4'h2, DEST_LINK, 1'b0);
		req(40'h00_7FFF_FFFF, 4'h2, DEST_MEM, 1'b0);
		req(40'hF0_0000_1000, 4'h2, DEST_MEM, 1'b0);
		req(40'h0F_0000_1000, 4'h2, DEST_MEM, 1'b0);
		req(40'h20_0000_0000, 4'h0, DEST_LINK, 1'b1);
		req(40'h00_1234_5678, 4'h6, DEST_LINK, 1'b0);
		$display("test fixed regions done");
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1;
		chk("rb_rerun", '0, {12'h0, rb_attr, rb_vga, rb_smm});
		req(40'h00_000C_8000, 4'h0, DEST_LINK, 1'b0);
		req(40'h00_000B_0000, 4'h2, DEST_LINK, 1'b0);
		req(40'h00_000F_8000, 4'hA, DEST_LINK, 1'b0);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule // tb_cad_decoder
`default_nettype wire
